// ===== hdl/gbu_ctrl.v
// What this block does
// - a change on the bank select pin reloads all nine outputs together, the update completing after about 760 us (750 us copy plus 10 us update).
// - pin low selects the curve in bank zero, pin high the curve in bank one.
// - copying a bank into the dac registers takes about 750 us, so it is too slow for per-frame changes.
// - a write with bit 15 clear changes only the staging register, never an output.
// - a write with bit 15 set to any dac or common voltage register moves all staged values to all outputs.
// - that simultaneous update happens on the same clock edge that takes in the committing write.
// - switch position eight makes the common voltage amplifier a unity buffer.
// - switch position one sets an external gain using an outside resistor with the string.
// - the gain setting lives at address 1ch, one-hot in the low byte, with bit 15 set.
`timescale 1ns/10ps
`default_nettype none
`include "gbu_defs.vh"

module gbu_ctrl #(
    parameter NCH        = `GBU_NCH,
    parameter DW         = `GBU_DAC_W,
    parameter COPY_CYC   = `GBU_COPY_CYC,
    parameter UPDATE_CYC = `GBU_UPDATE_CYC
) (
    input  wire                  i_core_clk,
    input  wire                  i_rst_n,
    input  wire                  i_bank_select_pin,
    input  wire                  i_wr_valid,
    input  wire [`GBU_ADDR_W-1:0] i_wr_addr,
    input  wire [15:0]           i_wr_data,
    input  wire                  i_nv_we,
    input  wire                  i_nv_bank,
    input  wire [`GBU_IDX_W-1:0] i_nv_idx,
    input  wire [DW-1:0]         i_nv_data,
    output reg  [NCH*DW-1:0]     o_dac_out,
    output reg  [`GBU_GAIN_W-1:0] o_common_voltage_gain_setting,
    output reg                   o_unity_buffer,
    output reg                   o_external_gain,
    output reg                   o_reload_busy
);
    // ==================================================================
    // sequencer states and fixed slots
    localparam [1:0] ST_IDLE = `GBU_ST_IDLE;
    localparam [1:0] ST_READ = `GBU_ST_READ;
    localparam [1:0] ST_WAIT = `GBU_ST_WAIT;
    // common voltage slot sits after the eight channels
    localparam [31:0] VCOM_IDX = NCH - 1;
    // switch outputs reset from the same word as the setting
    localparam [`GBU_GAIN_W-1:0] GAIN_RST = `GBU_GAIN_RST;

    // ==================================================================
    // pin synchroniser and edge detect
    reg                   bsel_m_r;
    reg                   bsel_s_r;
    reg                   bsel_d_r;
    wire                  bsel_edge;

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            bsel_m_r <= 1'b0;
            bsel_s_r <= 1'b0;
            bsel_d_r <= 1'b0;
        end else begin
            bsel_m_r <= i_bank_select_pin;
            bsel_s_r <= bsel_m_r;
            bsel_d_r <= bsel_s_r;
        end
    end
    // first flop feeds only the second
    assign bsel_edge = bsel_s_r ^ bsel_d_r;

    // ==================================================================
    // address decode
    wire                  is_ch;
    wire                  is_vcom;
    wire                  is_dac;
    wire [`GBU_IDX_W-1:0] wr_idx;
    wire                  commit;

    assign is_ch   = (i_wr_addr <= `GBU_ADDR_CH_LAST);
    assign is_vcom = (i_wr_addr == `GBU_ADDR_VCOM);
    assign is_dac  = i_wr_valid & (is_ch | is_vcom);
    assign wr_idx  = is_vcom ? VCOM_IDX[`GBU_IDX_W-1:0]
                             : i_wr_addr[`GBU_IDX_W-1:0];
    assign commit  = is_dac & i_wr_data[`GBU_COMMIT_BIT];

    // ==================================================================
    // reload sequencer
    reg  [1:0]            state_r;
    reg  [1:0]            state_nxt;
    reg  [`GBU_IDX_W-1:0] idx_r;
    reg  [`GBU_IDX_W-1:0] idx_nxt;
    reg                   bank_r;
    reg                   bank_nxt;
    reg                   rd_vld_r;
    reg  [`GBU_IDX_W-1:0] rd_idx_r;
    reg  [31:0]           cnt_r;
    reg  [31:0]           cnt_nxt;
    reg                   load_all;
    wire [DW-1:0]         nv_rdata;
    wire [`GBU_MEM_AW-1:0] rd_addr;
    wire [`GBU_MEM_AW-1:0] wr_addr;

    // bank is the address msb: pin low picks bank zero
    assign rd_addr = {bank_r, idx_r};
    assign wr_addr = {i_nv_bank, i_nv_idx};

    gbu_bank_mem #(
        .DW (DW),
        .AW (`GBU_MEM_AW)
    ) u_mem (
        .i_core_clk (i_core_clk),
        .i_we       (i_nv_we),
        .i_waddr    (wr_addr),
        .i_wdata    (i_nv_data),
        .i_raddr    (rd_addr),
        .o_rdata    (nv_rdata)
    );

    always @* begin
        state_nxt = state_r;
        idx_nxt   = idx_r;
        bank_nxt  = bank_r;
        cnt_nxt   = cnt_r;
        load_all  = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (bsel_edge) begin
                    state_nxt = ST_READ;
                    bank_nxt  = bsel_s_r;
                    idx_nxt   = {`GBU_IDX_W{1'b0}};
                    cnt_nxt   = 32'h0;
                end
            end
            ST_READ: begin
                cnt_nxt = cnt_r + 32'h1;
                if (idx_r == NCH - 1) begin
                    state_nxt = ST_WAIT;
                end else begin
                    idx_nxt = idx_r + 4'h1;
                end
            end
            ST_WAIT: begin
                // slow copy modelled as wait; too slow for per-frame use
                cnt_nxt = cnt_r + 32'h1;
                if (cnt_r >= COPY_CYC + UPDATE_CYC - 1) begin
                    load_all  = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_r  <= ST_IDLE;
            idx_r    <= {`GBU_IDX_W{1'b0}};
            bank_r   <= 1'b0;
            cnt_r    <= 32'h0;
            rd_vld_r <= 1'b0;
            rd_idx_r <= {`GBU_IDX_W{1'b0}};
        end else begin
            state_r  <= state_nxt;
            idx_r    <= idx_nxt;
            bank_r   <= bank_nxt;
            cnt_r    <= cnt_nxt;
            rd_vld_r <= (state_r == ST_READ);
            rd_idx_r <= idx_r;
        end
    end

    // ==================================================================
    // double-buffered channel registers
    reg [DW-1:0] stage_r [0:NCH-1];

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_ch
            always @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    stage_r[g] <= {DW{1'b0}};
                end else if (rd_vld_r && rd_idx_r == g) begin
                    stage_r[g] <= nv_rdata;
                end else if (is_dac && wr_idx == g) begin
                    stage_r[g] <= i_wr_data[DW-1:0];
                end
            end
            always @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    o_dac_out[g*DW +: DW] <= {DW{1'b0}};
                end else if (commit) begin
                    // committing word bypasses its stage slot, same cycle
                    o_dac_out[g*DW +: DW] <= (wr_idx == g) ?
                        i_wr_data[DW-1:0] : stage_r[g];
                end else if (load_all) begin
                    o_dac_out[g*DW +: DW] <= stage_r[g];
                end
            end
        end
    endgenerate

    // ==================================================================
    // common voltage gain setting
    wire gain_wr;
    assign gain_wr = i_wr_valid & (i_wr_addr == `GBU_ADDR_GAIN)
                   & i_wr_data[`GBU_COMMIT_BIT];

    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_common_voltage_gain_setting <= `GBU_GAIN_RST;
            o_unity_buffer                <= GAIN_RST[7];
            o_external_gain               <= GAIN_RST[0];
            o_reload_busy                 <= 1'b0;
        end else begin
            o_reload_busy <= (state_nxt != ST_IDLE);
            if (gain_wr) begin
                o_common_voltage_gain_setting <=
                    i_wr_data[`GBU_GAIN_W-1:0];
                o_unity_buffer  <= i_wr_data[7];
                o_external_gain <= i_wr_data[0];
            end
        end
    end
endmodule // gbu_ctrl
`default_nettype wire

// ===== hdl/gbu_defs.vh
`ifndef GBU_DEFS_VH
`define GBU_DEFS_VH

// ======================================================================
// addresses of the writable registers
`define GBU_ADDR_W          6
`define GBU_ADDR_CH_FIRST   6'h00
`define GBU_ADDR_CH_LAST    6'h07
`define GBU_ADDR_VCOM       6'h12
`define GBU_ADDR_GAIN       6'h1c

// ======================================================================
// write data fields
`define GBU_COMMIT_BIT      15
`define GBU_DAC_W           10
`define GBU_GAIN_W          8

// ======================================================================
// reset values
`define GBU_GAIN_RST        8'h01

// ======================================================================
// channel count and bank memory
`define GBU_NCH             9
`define GBU_IDX_W           4
`define GBU_MEM_AW          5

// ======================================================================
// timing: figures in ns, counts in cycles at the core clock
`define GBU_CLK_NS          40
`define GBU_UPDATE_NS       10000
`define GBU_UPDATE_CYC      (`GBU_UPDATE_NS / `GBU_CLK_NS)
`define GBU_COPY_NS         750000
`define GBU_COPY_CYC        (`GBU_COPY_NS / `GBU_CLK_NS)

// ======================================================================
// controller states
`define GBU_ST_IDLE         2'h0
`define GBU_ST_READ         2'h1
`define GBU_ST_WAIT         2'h2

`endif

// ===== hdl/gbu_bank_mem.v
`timescale 1ns/10ps
`default_nettype none
`include "gbu_defs.vh"

// ======================================================================
// two-bank curve store, registered read; bank is address msb
module gbu_bank_mem #(
    parameter DW = `GBU_DAC_W,
    parameter AW = `GBU_MEM_AW
) (
    input  wire          i_core_clk,
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [DW-1:0] i_wdata,
    input  wire [AW-1:0] i_raddr,
    output reg  [DW-1:0] o_rdata
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];

    always @(posedge i_core_clk) begin
        if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_r[i_raddr];
    end
endmodule // gbu_bank_mem
`default_nettype wire

// ===== verification/gbu_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// port checker for the update controller
module gbu_ctrl_properties #(
    parameter COPY_CYC   = 20,
    parameter UPDATE_CYC = 5
) (
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    input wire logic        i_bank_select_pin,
    input wire logic        i_wr_valid,
    input wire logic [5:0]  i_wr_addr,
    input wire logic [15:0] i_wr_data,
    input wire logic [89:0] o_dac_out,
    input wire logic [7:0]  o_common_voltage_gain_setting,
    input wire logic        o_unity_buffer,
    input wire logic        o_external_gain,
    input wire logic        o_reload_busy
);
    // window allows a few cycles of sync and read latency
    localparam int LO = COPY_CYC + UPDATE_CYC;
    localparam int HI = LO + 14;
    wire logic wr_ok = i_wr_valid && !o_reload_busy;
    wire logic gain_wr = i_wr_valid && i_wr_addr == 6'h1c;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    AST_STAGE_ONLY: assert property (
        wr_ok && !i_wr_data[15] |=> $stable(o_dac_out))
        else $error("staging write moved an output");
    AST_COMMIT_CH: assert property (
        wr_ok && i_wr_data[15] && i_wr_addr <= 6'h07 |=>
        o_dac_out[$past(i_wr_addr[2:0]) * 10 +: 10] == $past(i_wr_data[9:0]))
        else $error("channel commit value wrong");
    AST_COMMIT_VCOM: assert property (
        wr_ok && i_wr_data[15] && i_wr_addr == 6'h12 |=>
        o_dac_out[89:80] == $past(i_wr_data[9:0]))
        else $error("common voltage commit value wrong");
    AST_GAIN_SET: assert property (
        gain_wr && i_wr_data[15] |=>
        o_common_voltage_gain_setting == $past(i_wr_data[7:0]))
        else $error("gain setting not written");
    AST_GAIN_KEEP: assert property (
        gain_wr && !i_wr_data[15] |=> $stable(o_common_voltage_gain_setting))
        else $error("gain changed without commit bit");
    AST_SWITCH: assert property (
        gain_wr && i_wr_data[15] |=> o_unity_buffer == $past(i_wr_data[7])
        && o_external_gain == $past(i_wr_data[0]))
        else $error("switch outputs disagree with gain");
    AST_SWITCH_TRACK: assert property (
        o_unity_buffer == o_common_voltage_gain_setting[7]
        && o_external_gain == o_common_voltage_gain_setting[0])
        else $error("switch outputs out of step with setting");
    AST_BUSY_START: assert property (
        !o_reload_busy && i_bank_select_pin != $past(i_bank_select_pin)
        |-> ##[1:4] o_reload_busy)
        else $error("pin change started no reload");
    AST_BUSY_HOLD: assert property (
        $rose(o_reload_busy) |-> o_reload_busy [*8])
        else $error("reload ended too early");
    AST_BUSY_END: assert property (
        $rose(o_reload_busy) |-> ##[LO:HI] $fell(o_reload_busy))
        else $error("reload length out of window");

    cover property (wr_ok && i_wr_data[15]);
    cover property ($fell(o_reload_busy));
    cover property (o_unity_buffer);
endmodule // gbu_ctrl_properties
`default_nettype wire

// ===== verification/gbu_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ======================================================================
// host side: one decoded write per call, then a gap cycle
module gbu_host_model (
    input  wire logic        i_core_clk,
    output var  logic        o_wr_valid,
    output var  logic [5:0]  o_wr_addr,
    output var  logic [15:0] o_wr_data
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr_addr  = 6'h3f;
        o_wr_data  = 16'hffff;
    end
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        #1;
        o_wr_valid = 1'b1;
        o_wr_addr  = a;
        o_wr_data  = d;
        @(posedge i_core_clk);
        #1;
        // released lines invert so stale data cannot pass
        o_wr_valid = 1'b0;
        o_wr_addr  = ~a;
        o_wr_data  = ~d;
    endtask
endmodule // gbu_host_model
`default_nettype wire

// ===== verification/tb_gbu_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_gbu_ctrl;
    logic core_clk = 0, rst_n = 0, pin = 0, nv_we = 0, nv_bank = 0;
    logic [3:0]  nv_idx  = 4'h0;
    logic [9:0]  nv_data = 10'h000;
    wire  logic  wv, unity, extg, busy;
    wire  logic [5:0]  wa;
    wire  logic [15:0] wd;
    wire  logic [89:0] dac;
    wire  logic [7:0]  gain;
    int err_total = 0, checks = 0;
    always #20 core_clk = ~core_clk;
    gbu_host_model u_host (.i_core_clk(core_clk), .o_wr_valid(wv),
        .o_wr_addr(wa), .o_wr_data(wd));
    gbu_ctrl #(.COPY_CYC(20), .UPDATE_CYC(5)) u_dut (.i_core_clk(core_clk),
        .i_rst_n(rst_n), .i_bank_select_pin(pin), .i_wr_valid(wv),
        .i_wr_addr(wa), .i_wr_data(wd), .i_nv_we(nv_we), .i_nv_bank(nv_bank),
        .i_nv_idx(nv_idx), .i_nv_data(nv_data), .o_dac_out(dac),
        .o_common_voltage_gain_setting(gain), .o_unity_buffer(unity),
        .o_external_gain(extg), .o_reload_busy(busy));
    task automatic chk(string n, logic [89:0] seen, logic [89:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic conclude;
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [9:0] val(input int b, input int k);
        return 10'(b * 64 + k * 7 + 1);
    endfunction
    function automatic logic [5:0] adr(input int k);
        return (k < 8) ? 6'(k) : 6'h12;
    endfunction
    task automatic t_reset;
        chk("dac_rst", dac, 0);
        chk("gain_rst", gain, 8'h01);
        chk("switch_rst", {unity, extg, busy}, 3'h2);
    endtask
    task automatic t_gain;
        for (int p = 0; p < 8; p++) begin
            u_host.wr(6'h1c, 16'h8000 | (16'h0001 << p));
            chk("gain", gain, 8'h01 << p);
            chk("unity", unity, p == 7);
            chk("ext_gain", extg, p == 0);
        end
        u_host.wr(6'h1c, 16'h0001);
        chk("gain_keep", gain, 8'h80);
    endtask
    task automatic t_stage_commit;
        logic [89:0] exp;
        for (int k = 0; k < 9; k++) begin
            u_host.wr(adr(k), {6'h00, val(1, k)});
            exp[k*10 +: 10] = val(1, k);
        end
        chk("dac_staged", dac, 0);
        u_host.wr(6'h03, {6'h20, val(1, 3)});
        chk("dac_commit", dac, exp);
        u_host.wr(6'h08, {6'h20, val(3, 0)});
        chk("dac_reserved", dac, exp);
        u_host.wr(6'h00, {6'h00, val(2, 0)});
        u_host.wr(6'h12, {6'h20, val(1, 8)});
        exp[9:0] = val(2, 0);
        chk("dac_vcom_commit", dac, exp);
    endtask
    task automatic t_bank;
        logic [89:0] exp, prev;
        int n;
        for (int m = 0; m < 18; m++) begin
            @(posedge core_clk);
            #1;
            nv_we = 1'b1;
            nv_bank = 1'(m / 9);
            nv_idx = 4'(m % 9);
            nv_data = val(m / 9 + 3, m % 9);
        end
        @(posedge core_clk);
        #1;
        nv_we = 1'b0;
        for (int b = 1; b >= 0; b--) begin
            pin = 1'(b);
            n = 0;
            while (busy !== 1'b1 && n < 8) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            prev = dac;
            n = 0;
            while (busy === 1'b1 && n < 60) begin
                chk("dac_hold", dac, prev);
                @(posedge core_clk);
                #1;
                n++;
            end
            if (n == 0 || n >= 60) begin
                err_total++;
                conclude();
            end
            chk("reload_len", n >= 25 && n <= 40, 1);
            for (int k = 0; k < 9; k++) exp[k*10 +: 10] = val(b + 3, k);
            chk("dac_bank", dac, exp);
            repeat (10) @(posedge core_clk);
            #1;
            chk("busy_once", busy, 0);
        end
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_gain();
        t_stage_commit();
        t_bank();
        conclude();
    end
endmodule // tb_gbu_ctrl
bind gbu_ctrl gbu_ctrl_properties #(.COPY_CYC(COPY_CYC),
    .UPDATE_CYC(UPDATE_CYC)) u_props (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_bank_select_pin(i_bank_select_pin),
    .i_wr_valid(i_wr_valid), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data),
    .o_dac_out(o_dac_out),
    .o_common_voltage_gain_setting(o_common_voltage_gain_setting),
    .o_unity_buffer(o_unity_buffer), .o_external_gain(o_external_gain),
    .o_reload_busy(o_reload_busy));
`default_nettype wire
